// >>> dmarsp_defs.svh
// register offsets, field positions, reset values and sizes of the dma register and status port
`ifndef DMARSP_DEFS_SVH
`define DMARSP_DEFS_SVH

// ==========================================
// word offsets
`define DMARSP_OFS_STATUS   3'h0
`define DMARSP_OFS_SRC      3'h1
`define DMARSP_OFS_DST      3'h2
`define DMARSP_OFS_LEN      3'h3
`define DMARSP_OFS_RSV4     3'h4
`define DMARSP_OFS_RSV5     3'h5
`define DMARSP_OFS_CTRL     3'h6
`define DMARSP_OFS_RSV7     3'h7

// ==========================================
// status bit positions
`define DMARSP_ST_DONE      0
`define DMARSP_ST_BUSY      1
`define DMARSP_ST_READ_SIDE_PACKET_END_FLAG      2
`define DMARSP_ST_WRITE_SIDE_PACKET_END_FLAG      3
`define DMARSP_ST_CZERO     4

// ==========================================
// control bit positions
`define DMARSP_CT_BYTE      0
`define DMARSP_CT_HALF      1
`define DMARSP_CT_WORD      2
`define DMARSP_CT_GO        3
`define DMARSP_CT_IEN       4
`define DMARSP_CT_READ_PACKET_END_ENABLE      5
`define DMARSP_CT_WRITE_PACKET_END_ENABLE      6
`define DMARSP_CT_COUNT_END_ENABLE      7
`define DMARSP_CT_RFIX      8
`define DMARSP_CT_WFIX      9
`define DMARSP_CT_DWORD     10
`define DMARSP_CT_QWORD     11
`define DMARSP_CT_SRST      12
`define DMARSP_CT_MSB       12

// ==========================================
// reset values and sizes
`define DMARSP_RST_WORD     32'h0000_0000
`define DMARSP_RST_CTRL     13'h0000
`define DMARSP_DATA_W       32
`define DMARSP_FIFO_DEPTH   16

`endif

// >>> dmarsp_fifo.sv
// buffer between read master and write master
`timescale 1ns/1ps
module dmarsp_fifo #(
  parameter int W       = 32,
  parameter int DEPTH   = 16,
  parameter bit USE_MEM = 1'b0
) (
  input  wire logic         core_clk,   // system clock
  input  wire logic         reset,      // sync reset, active high
  input  wire logic         ce,         // clock enable
  input  wire logic         in_valid,   // write side valid
  output logic              in_ready,   // write side ready
  input  wire logic [W-1:0] in_data,    // write side data
  output logic              out_valid,  // read side valid
  input  wire logic         out_ready,  // read side ready
  output logic      [W-1:0] out_data    // read side data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] store [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic [AW:0]  next_wr_ptr;
  logic [AW:0]  next_rd_ptr;
  logic         push;
  logic         pop;

  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = store[rd_ptr[AW-1:0]];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // memory build leaves contents unreset so the array maps onto ram blocks
  generate
    if (USE_MEM) begin : g_mem
      always_ff @(posedge core_clk) begin
        if (push) begin
          store[wr_ptr[AW-1:0]] <= in_data;
        end
      end
    end else begin : g_reg
      always_ff @(posedge core_clk) begin
        if (reset) begin
          for (int i = 0; i < DEPTH; i++) begin
            store[i] <= '0;
          end
        end else if (push) begin
          store[wr_ptr[AW-1:0]] <= in_data;
        end
      end
    end
  endgenerate
endmodule

// >>> dmarsp_pkg.sv
// types shared by the dma register and status port
package dmarsp_pkg;
  typedef enum logic [0:0] {
    DMARSP_IDLE,
    DMARSP_RUN
  } dmarsp_state_t;
  typedef logic [31:0] dmarsp_word_t;
endpackage

// >>> dmarsp_regs.sv
// register window, status flags and transfer gating of the dma engine
`timescale 1ns/1ps
`include "dmarsp_defs.svh"

// Summary of operation
// [RULE_01] five usable 32-bit registers live in an eight-word window
// [RULE_02] word 1 holds the read/write source start address
// [RULE_03] word 2 holds the read/write destination start address
// [RULE_04] word 3 holds the transfer length in bytes, read/write
// [RULE_05] words 4, 5, 7 are reserved; here they read zero, writes ignored
// [RULE_06] software writes zero to reserved bits and ignores their read value
// [RULE_07] done sets on a packet end or when the length is fully moved
// [RULE_08] writing the status register clears done, count zero and both packet flags
// [RULE_09] busy reads one while a transaction runs, zero otherwise
// [RULE_10] status bit 2 marks an end caused by read-side packet end
// [RULE_11] status bit 3 marks an end caused by write-side packet end
// [RULE_12] count zero flag sets when the length counts down to zero
// [RULE_13] reading status never changes any flag
// [RULE_14] source address gives first read location, width fixed at build
// [RULE_15] each transfer width is enabled by a build option, disabled logic dropped
// [RULE_16] a build option builds the buffer from memory blocks instead of flops
// [RULE_17] control bits 0..12 are the documented width, enable and reset fields
// [RULE_18] interrupt is high exactly while done and interrupt enable are set
// [RULE_19] length drops per written value and never below zero
// [RULE_20] transfers run only with run enable set and length non-zero
// [RULE_21] slave offsets are word indices, one whole register each
module dmarsp_regs
  import dmarsp_pkg::*;
#(
  parameter bit ALLOW_BYTE  = 1'b1,
  parameter bit ALLOW_HALF  = 1'b1,
  parameter bit ALLOW_WORD  = 1'b1,
  parameter bit ALLOW_DWORD = 1'b1,
  parameter bit ALLOW_QWORD = 1'b1,
  parameter bit FIFO_MEM    = 1'b0
) (
  input  wire logic                      core_clk,    // system clock
  input  wire logic                      reset,       // sync reset, active high
  input  wire logic                      ce,          // clock enable, freezes all state
  input  wire logic [2:0]                slv_address, // word index
  input  wire logic                      slv_write,   // write strobe
  input  wire logic                      slv_read,    // read strobe
  input  wire logic [31:0]               slv_wdata,   // write data
  output logic      [31:0]               slv_rdata,   // read data, one cycle after read
  output logic                           irq,         // interrupt request
  output logic      [31:0]               src_addr,    // source start address
  output logic      [31:0]               dst_addr,    // destination start address
  output logic                           src_fixed,   // source address held constant
  output logic                           dst_fixed,   // destination address held constant
  output logic      [4:0]                width_sel,   // byte..quad width bits, copied from control
  output logic                           run,         // transfer enable to masters
  input  wire logic                      rd_eop,      // read-side packet end pulse
  input  wire logic                      wr_eop,      // write-side packet end pulse
  input  wire logic                      rd_valid,    // read master data valid
  output logic                           rd_ready,    // buffer can take read data
  input  wire logic [`DMARSP_DATA_W-1:0] rd_data,     // read master data
  output logic                           wr_valid,    // data for write master
  input  wire logic                      wr_ready,    // write master accepts data
  output logic      [`DMARSP_DATA_W-1:0] wr_data      // data to write master
);

  // ==========================================
  // bytes moved per written value
  function automatic logic [4:0] step_bytes(input logic [`DMARSP_CT_MSB:0] c);
    step_bytes = 5'h00;
    if (ALLOW_BYTE && c[`DMARSP_CT_BYTE]) step_bytes = 5'h01; // RULE_15
    else if (ALLOW_HALF && c[`DMARSP_CT_HALF]) step_bytes = 5'h02;
    else if (ALLOW_WORD && c[`DMARSP_CT_WORD]) step_bytes = 5'h04;
    else if (ALLOW_DWORD && c[`DMARSP_CT_DWORD]) step_bytes = 5'h08;
    else if (ALLOW_QWORD && c[`DMARSP_CT_QWORD]) step_bytes = 5'h10;
  endfunction

  dmarsp_state_t              state;
  dmarsp_state_t              next_state;
  logic [31:0]                length;
  logic [31:0]                next_length;
  logic [31:0]                next_src_addr;
  logic [31:0]                next_dst_addr;
  logic [`DMARSP_CT_MSB:0]    ctrl;
  logic [`DMARSP_CT_MSB:0]    next_ctrl;
  logic                       done;
  logic                       next_done;
  logic                       read_side_packet_end_flag;
  logic                       next_read_side_packet_end_flag;
  logic                       write_side_packet_end_flag;
  logic                       next_write_side_packet_end_flag;
  logic                       czero;
  logic                       next_czero;
  logic                       srst_armed;
  logic                       next_srst_armed;
  logic                       srst;
  logic                       next_srst;
  logic [31:0]                next_rdata;
  logic                       int_rst;
  logic                       wr_st;
  logic                       wr_src;
  logic                       wr_dst;
  logic                       wr_len;
  logic                       wr_ctl;
  logic [4:0]                 step;
  logic                       beat;
  logic                       fifo_out_valid;
  logic                       fifo_out_ready;
  logic [31:0]                status_word;

  // second write of one to the reset trigger behaves like a system reset
  assign int_rst = reset || srst;

  // ==========================================
  // address decode
  always_comb begin
    wr_st  = 1'b0;
    wr_src = 1'b0;
    wr_dst = 1'b0;
    wr_len = 1'b0;
    wr_ctl = 1'b0;
    if (!slv_write) begin
      wr_st = 1'b0;
    end else if (slv_address == `DMARSP_OFS_STATUS) begin // RULE_21
      wr_st = 1'b1;
    end else if (slv_address == `DMARSP_OFS_SRC) begin
      wr_src = 1'b1;
    end else if (slv_address == `DMARSP_OFS_DST) begin
      wr_dst = 1'b1;
    end else if (slv_address == `DMARSP_OFS_LEN) begin
      wr_len = 1'b1;
    end else if (slv_address == `DMARSP_OFS_CTRL) begin
      wr_ctl = 1'b1;
    end
  end

  // ==========================================
  // transfer gating and buffer
  assign step           = step_bytes(ctrl);
  assign run            = (state == DMARSP_RUN) && ctrl[`DMARSP_CT_GO] && (length != '0); // RULE_20
  assign wr_valid       = fifo_out_valid && run;
  assign fifo_out_ready = wr_ready && run;
  assign beat           = wr_valid && wr_ready;
  assign src_fixed      = ctrl[`DMARSP_CT_RFIX];
  assign dst_fixed      = ctrl[`DMARSP_CT_WFIX];
  assign width_sel      = {ctrl[`DMARSP_CT_QWORD], ctrl[`DMARSP_CT_DWORD], ctrl[`DMARSP_CT_WORD],
                           ctrl[`DMARSP_CT_HALF], ctrl[`DMARSP_CT_BYTE]};
  assign irq            = done && ctrl[`DMARSP_CT_IEN]; // RULE_18

  dmarsp_fifo #(
    .W       (`DMARSP_DATA_W),
    .DEPTH   (`DMARSP_FIFO_DEPTH),
    .USE_MEM (FIFO_MEM)
  ) u_fifo (
    .core_clk  (core_clk),
    .reset     (int_rst),
    .ce        (ce),
    .in_valid  (rd_valid),
    .in_ready  (rd_ready),
    .in_data   (rd_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (wr_data)
  ); // RULE_16

  // ==========================================
  // next state of registers and flags
  always_comb begin
    logic end_r;
    logic end_w;
    logic end_l;
    end_r           = 1'b0;
    end_w           = 1'b0;
    end_l           = 1'b0;
    next_state      = state;
    next_length     = length;
    next_src_addr   = wr_src ? slv_wdata : src_addr; // RULE_02 RULE_14
    next_dst_addr   = wr_dst ? slv_wdata : dst_addr; // RULE_03
    next_ctrl       = wr_ctl ? slv_wdata[`DMARSP_CT_MSB:0] : ctrl; // RULE_17 RULE_06
    next_srst_armed = srst_armed;
    next_srst       = 1'b0;
    // clear first, so an event in the same cycle still sets its flag
    next_done       = wr_st ? 1'b0 : done; // RULE_08
    next_read_side_packet_end_flag       = wr_st ? 1'b0 : read_side_packet_end_flag;
    next_write_side_packet_end_flag       = wr_st ? 1'b0 : write_side_packet_end_flag;
    next_czero      = wr_st ? 1'b0 : czero;
    if (wr_len) begin
      next_length = slv_wdata; // RULE_04
    end else if (beat) begin
      next_length = (length > 32'(step)) ? length - 32'(step) : '0; // RULE_19
      if (length <= 32'(step)) begin
        next_czero = 1'b1; // RULE_12
        end_l      = ctrl[`DMARSP_CT_COUNT_END_ENABLE];
      end
    end
    if (wr_ctl && slv_wdata[`DMARSP_CT_SRST]) begin
      next_srst_armed = !srst_armed;
      next_srst       = srst_armed;
    end
    case (state)
      DMARSP_IDLE: begin
        if (ctrl[`DMARSP_CT_GO] && (length != '0) && !done) begin
          next_state = DMARSP_RUN;
        end
      end
      DMARSP_RUN: begin
        end_r = rd_eop && ctrl[`DMARSP_CT_READ_PACKET_END_ENABLE];
        end_w = wr_eop && ctrl[`DMARSP_CT_WRITE_PACKET_END_ENABLE];
        if (end_r) begin
          next_read_side_packet_end_flag = 1'b1; // RULE_10
        end
        if (end_w) begin
          next_write_side_packet_end_flag = 1'b1; // RULE_11
        end
        if (end_r || end_w || end_l) begin
          next_done  = 1'b1; // RULE_07
          next_state = DMARSP_IDLE;
        end else if (!ctrl[`DMARSP_CT_GO]) begin
          next_state = DMARSP_IDLE;
        end
      end
      default: begin
        next_state = DMARSP_IDLE;
      end
    endcase
  end

  // ==========================================
  // read data; reserved words answer zero
  assign status_word = {27'h0, czero, write_side_packet_end_flag, read_side_packet_end_flag, (state == DMARSP_RUN), done}; // RULE_09

  always_comb begin
    next_rdata = `DMARSP_RST_WORD;
    if (!slv_read) begin
      next_rdata = slv_rdata;
    end else if (slv_address == `DMARSP_OFS_STATUS) begin
      next_rdata = status_word; // RULE_13
    end else if (slv_address == `DMARSP_OFS_SRC) begin
      next_rdata = src_addr;
    end else if (slv_address == `DMARSP_OFS_DST) begin
      next_rdata = dst_addr;
    end else if (slv_address == `DMARSP_OFS_LEN) begin
      next_rdata = length;
    end else if (slv_address == `DMARSP_OFS_CTRL) begin
      next_rdata = {19'h0, ctrl};
    end else begin
      next_rdata = `DMARSP_RST_WORD; // RULE_05 RULE_01
    end
  end

  always_ff @(posedge core_clk) begin
    if (int_rst) begin
      state      <= DMARSP_IDLE;
      length     <= `DMARSP_RST_WORD;
      src_addr   <= `DMARSP_RST_WORD;
      dst_addr   <= `DMARSP_RST_WORD;
      ctrl       <= `DMARSP_RST_CTRL;
      done       <= 1'b0;
      read_side_packet_end_flag       <= 1'b0;
      write_side_packet_end_flag       <= 1'b0;
      czero      <= 1'b0;
      srst_armed <= 1'b0;
      srst       <= 1'b0;
      slv_rdata  <= `DMARSP_RST_WORD;
    end else if (ce) begin
      state      <= next_state;
      length     <= next_length;
      src_addr   <= next_src_addr;
      dst_addr   <= next_dst_addr;
      ctrl       <= next_ctrl;
      done       <= next_done;
      read_side_packet_end_flag       <= next_read_side_packet_end_flag;
      write_side_packet_end_flag       <= next_write_side_packet_end_flag;
      czero      <= next_czero;
      srst_armed <= next_srst_armed;
      srst       <= next_srst;
      slv_rdata  <= next_rdata;
    end
  end

  // ==========================================
  // checks
  property p_status_clear;
    @(posedge core_clk) disable iff (int_rst)
    (ce && wr_st && !beat && !rd_eop && !wr_eop) |=> (!done && !read_side_packet_end_flag && !write_side_packet_end_flag && !czero);
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status write left a flag set"); // RULE_08

  property p_read_quiet;
    @(posedge core_clk) disable iff (reset)
    (ce && slv_read && !slv_write && !beat && !rd_eop && !wr_eop && !srst && state == DMARSP_IDLE)
      |=> ($stable(done) && $stable(read_side_packet_end_flag) && $stable(write_side_packet_end_flag) && $stable(czero));
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("status read changed a flag"); // RULE_13

  property p_busy_start;
    @(posedge core_clk) disable iff (int_rst)
    (ce && state == DMARSP_IDLE && ctrl[`DMARSP_CT_GO] && length != '0 && !done && !wr_st && !wr_ctl)
      |=> status_word[`DMARSP_ST_BUSY];
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy did not rise on start"); // RULE_09

  property p_len_floor;
    @(posedge core_clk) disable iff (int_rst)
    (ce && beat && !wr_len && length <= 32'(step)) |=> (length == '0 && czero);
  endproperty
  a_len_floor: assert property (p_len_floor) else $error("length passed below zero"); // RULE_19 RULE_12

  property p_no_go;
    @(posedge core_clk) disable iff (int_rst)
    (!ctrl[`DMARSP_CT_GO] || length == '0)
      |-> (!wr_valid ##1 (!$past(ce) || $past(wr_len) || length == $past(length)));
  endproperty
  a_no_go: assert property (p_no_go) else $error("transfer offered while stopped"); // RULE_20

  property p_read_side_packet_end_flag_end;
    @(posedge core_clk) disable iff (int_rst)
    (ce && state == DMARSP_RUN && rd_eop && ctrl[`DMARSP_CT_READ_PACKET_END_ENABLE]) |=> (done && read_side_packet_end_flag && state == DMARSP_IDLE);
  endproperty
  a_read_side_packet_end_flag_end: assert property (p_read_side_packet_end_flag_end) else $error("read packet end did not finish"); // RULE_10 RULE_07

  property p_write_side_packet_end_flag_end;
    @(posedge core_clk) disable iff (int_rst)
    (ce && state == DMARSP_RUN && wr_eop && ctrl[`DMARSP_CT_WRITE_PACKET_END_ENABLE]) |=> (done && write_side_packet_end_flag);
  endproperty
  a_write_side_packet_end_flag_end: assert property (p_write_side_packet_end_flag_end) else $error("write packet end did not finish"); // RULE_11

  property p_irq_follow;
    @(posedge core_clk) disable iff (int_rst)
    (ce && state == DMARSP_RUN && rd_eop && ctrl[`DMARSP_CT_READ_PACKET_END_ENABLE] && ctrl[`DMARSP_CT_IEN] && !wr_ctl)
      |=> irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("interrupt missing after end"); // RULE_18

  property p_src_write;
    @(posedge core_clk) disable iff (int_rst)
    (ce && wr_src) |=> (src_addr == $past(slv_wdata));
  endproperty
  a_src_write: assert property (p_src_write) else $error("source address not stored"); // RULE_02
endmodule

// >>> dmarsp_stream_model.sv
// stream source and sink at the far side of the dma buffer
`timescale 1ns/1ps
module dmarsp_stream_model (
  input  wire logic        core_clk, // system clock
  input  wire logic        clr,      // restart both sequences
  input  wire logic        src_en,   // source offers data
  input  wire logic        sink_en,  // sink accepts data
  input  wire logic        rd_ready, // buffer can take data
  output logic             rd_valid, // source data valid
  output logic      [31:0] rd_data,  // source data
  input  wire logic        wr_valid, // buffer data valid
  output logic             wr_ready, // sink accepts data
  input  wire logic [31:0] wr_data,  // buffer data
  output int               n_push,   // words taken by the buffer
  output int               n_pop,    // words taken by the sink
  output int               n_bad     // words out of order
);
  logic [31:0] seq;
  // ==========================================
  // source holds data until taken; idle data is inverted so stale values never match
  assign seq      = 32'hA500_0000 + 32'(n_push);
  assign rd_valid = src_en;
  assign rd_data  = src_en ? seq : ~seq;
  assign wr_ready = sink_en;
  always_ff @(posedge core_clk) begin
    if (clr) begin
      n_push <= 0;
      n_pop  <= 0;
      n_bad  <= 0;
    end else begin
      if (rd_valid && rd_ready) n_push <= n_push + 1;
      if (wr_valid && wr_ready) begin
        n_pop <= n_pop + 1;
        if (wr_data !== 32'hA500_0000 + 32'(n_pop)) n_bad <= n_bad + 1;
      end
    end
  end
endmodule

// >>> tb_dmarsp_regs.sv
// self-checking testbench of the dma register and status port
`timescale 1ns/1ps
`include "dmarsp_defs.svh"
module tb_dmarsp_regs;
  logic        core_clk, reset, ce, slv_write, slv_read, rd_eop, wr_eop;
  logic [2:0]  slv_address;
  logic [31:0] slv_wdata, slv_rdata, src_addr, dst_addr, rd_data, wr_data, st;
  logic        irq, src_fixed, dst_fixed, run, rd_valid, rd_ready, wr_valid, wr_ready;
  logic        src_en, sink_en;
  logic [4:0]  width_sel;
  int          num_errors, n_compared, n_push, n_pop, n_bad;
  localparam logic [31:0] GO   = 32'h0000_0001 << `DMARSP_CT_GO;
  localparam logic [31:0] WORD = 32'h0000_0001 << `DMARSP_CT_WORD;
  localparam logic [31:0] COUNT_END_ENABLE = 32'h0000_0001 << `DMARSP_CT_COUNT_END_ENABLE;
  localparam logic [31:0] IEN  = 32'h0000_0001 << `DMARSP_CT_IEN;
  localparam logic [31:0] READ_PACKET_END_ENABLE = 32'h0000_0001 << `DMARSP_CT_READ_PACKET_END_ENABLE;
  localparam logic [31:0] WRITE_PACKET_END_ENABLE = 32'h0000_0001 << `DMARSP_CT_WRITE_PACKET_END_ENABLE;
  localparam logic [31:0] SRST = 32'h0000_0001 << `DMARSP_CT_SRST;

  dmarsp_regs dut_u (.core_clk(core_clk), .reset(reset), .ce(ce), .slv_address(slv_address),
    .slv_write(slv_write), .slv_read(slv_read), .slv_wdata(slv_wdata), .slv_rdata(slv_rdata),
    .irq(irq), .src_addr(src_addr), .dst_addr(dst_addr), .src_fixed(src_fixed),
    .dst_fixed(dst_fixed), .width_sel(width_sel), .run(run), .rd_eop(rd_eop), .wr_eop(wr_eop),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data));
  dmarsp_stream_model far_u (.core_clk(core_clk), .clr(reset), .src_en(src_en), .sink_en(sink_en),
    .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .n_push(n_push), .n_pop(n_pop), .n_bad(n_bad));

  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(negedge core_clk);
    slv_write   = 1'b1;
    slv_address = a;
    slv_wdata   = d;
    @(negedge core_clk);
    slv_write = 1'b0;
  endtask
  // data is sampled one full cycle after the strobe drops; it holds until the next read
  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    @(negedge core_clk);
    slv_read    = 1'b1;
    slv_address = a;
    @(negedge core_clk);
    slv_read = 1'b0;
    @(negedge core_clk);
    d = slv_rdata;
  endtask
  task automatic do_reset();
    @(negedge core_clk);
    reset   = 1'b1;
    src_en  = 1'b0;
    sink_en = 1'b0;
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 200; i++) begin
      rd(3'h0, st);
      if (st[0] === 1'b1) break;
    end
  endtask
  task automatic pulse(input bit side);
    @(negedge core_clk);
    if (side) wr_eop = 1'b1;
    else rd_eop = 1'b1;
    @(negedge core_clk);
    rd_eop = 1'b0;
    wr_eop = 1'b0;
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    do_reset();
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], st);
      chk(st, 32'h0000_0000);
    end
    chk(irq, 1'b0);
    chk(run, 1'b0);
    $display("test reset values done");
  endtask
  task automatic t_regs();
    do_reset();
    wr(3'h1, 32'h1234_5678);
    wr(3'h2, 32'h89AB_CDEF);
    wr(3'h3, 32'h0000_0100);
    wr(3'h6, ~(SRST | GO | IEN) & 32'h0000_1FFF);
    for (int a = 4; a < 8; a++) if (a != 6) wr(a[2:0], 32'hFFFF_FFFF);
    rd(3'h1, st); chk(st, 32'h1234_5678);
    rd(3'h2, st); chk(st, 32'h89AB_CDEF);
    rd(3'h3, st); chk(st, 32'h0000_0100);
    rd(3'h6, st); chk(st, 32'h0000_0FE7);
    rd(3'h4, st); chk(st, 32'h0000_0000);
    rd(3'h5, st); chk(st, 32'h0000_0000);
    rd(3'h7, st); chk(st, 32'h0000_0000);
    chk(src_addr, 32'h1234_5678);
    chk(dst_addr, 32'h89AB_CDEF);
    chk({src_fixed, dst_fixed, width_sel}, 7'h7F);
    $display("test register access done");
  endtask
  task automatic t_fill_drain();
    do_reset();
    src_en = 1'b1;
    for (int i = 0; i < 40 && rd_ready !== 1'b0; i++) @(negedge core_clk);
    src_en = 1'b0;
    chk(n_push, 16);
    wr(3'h3, 32'h0000_0040);
    wr(3'h6, WORD | GO | COUNT_END_ENABLE | IEN);
    rd(3'h0, st); chk(st, 32'h0000_0002);
    chk(run, 1'b1);
    sink_en = 1'b1;
    wait_done();
    chk(st, 32'h0000_0011);
    rd(3'h0, st); chk(st, 32'h0000_0011);
    chk(irq, 1'b1);
    chk(n_pop, 16);
    chk(n_bad, 0);
    rd(3'h3, st); chk(st, 32'h0000_0000);
    wr(3'h0, 32'h0000_0000);
    rd(3'h0, st); chk(st, 32'h0000_0000);
    chk(irq, 1'b0);
    $display("test fill and drain done");
  endtask
  task automatic t_widths();
    int pos[5] = '{0, 1, 2, 10, 11};
    for (int w = 0; w < 5; w++) begin
      do_reset();
      src_en  = 1'b1;
      sink_en = 1'b1;
      wr(3'h3, 32'd3 << w);
      wr(3'h6, (32'h0000_0001 << pos[w]) | GO | COUNT_END_ENABLE);
      wait_done();
      chk(st, 32'h0000_0011);
      chk(n_pop, 3);
    end
    $display("test transfer widths done");
  endtask
  task automatic t_eop();
    for (int k = 0; k < 2; k++) begin
      do_reset();
      wr(3'h3, 32'h0000_0040);
      wr(3'h6, WORD | GO | IEN | (k ? WRITE_PACKET_END_ENABLE : READ_PACKET_END_ENABLE));
      pulse(k == 0);
      rd(3'h0, st); chk(st, 32'h0000_0002);
      chk(irq, 1'b0);
      pulse(k == 1);
      rd(3'h0, st); chk(st, k ? 32'h0000_0009 : 32'h0000_0005);
      chk(irq, 1'b1);
      rd(3'h3, st); chk(st, 32'h0000_0040);
    end
    $display("test packet end done");
  endtask
  task automatic t_gate();
    do_reset();
    src_en  = 1'b1;
    sink_en = 1'b1;
    wr(3'h3, 32'h0000_0008);
    wr(3'h6, WORD);
    repeat (20) @(negedge core_clk);
    chk({wr_valid, 31'(n_pop)}, 32'h0000_0000);
    wr(3'h6, WORD | GO);
    for (int i = 0; i < 50 && n_pop < 2; i++) @(negedge core_clk);
    rd(3'h0, st); chk(st, 32'h0000_0012);
    chk(n_pop, 2);
    wr(3'h6, WORD);
    rd(3'h0, st); chk(st, 32'h0000_0010);
    $display("test run gating done");
  endtask
  task automatic t_soft();
    do_reset();
    wr(3'h1, 32'h5555_AAAA);
    @(negedge core_clk);
    ce = 1'b0;
    wr(3'h1, 32'h0000_0000);
    ce = 1'b1;
    rd(3'h1, st); chk(st, 32'h5555_AAAA);
    wr(3'h6, SRST);
    wr(3'h6, SRST);
    repeat (3) @(negedge core_clk);
    rd(3'h1, st); chk(st, 32'h0000_0000);
    rd(3'h6, st); chk(st, 32'h0000_0000);
    $display("test soft reset done");
  endtask

  // ==========================================
  // run control
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    reset = 1'b1; ce = 1'b1; slv_write = 1'b0; slv_read = 1'b0; slv_address = 3'h0;
    slv_wdata = 32'h0000_0000; rd_eop = 1'b0; wr_eop = 1'b0; src_en = 1'b0; sink_en = 1'b0;
    num_errors = 0;
    n_compared = 0;
    t_reset();
    t_regs();
    t_fill_drain();
    t_widths();
    t_eop();
    t_gate();
    t_soft();
    final_report();
  end
  // the whole sequence needs a few hundred cycles; this leaves ample slack
  initial begin
    #(20000 * 4);
    num_errors++;
    final_report();
  end
endmodule
